// [design/cfs_pkg.sv]
// Package: register map, field layout and reset values of the FIFO status,
// timestamp timer and acceptance mask block.
// Assumes a 32-bit APB slave with word-aligned registers.
package cfs_pkg;
  localparam logic [7:0] CFS_OFF_FIFO_PEND = 8'h00;
  localparam logic [7:0] CFS_OFF_RX_OVF = 8'h04;
  localparam logic [7:0] CFS_OFF_TIMER = 8'h08;
  localparam logic [7:0] CFS_OFF_CTRL = 8'h0C;
  localparam logic [7:0] CFS_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] CFS_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] CFS_OFF_MASK0 = 8'h20;
  localparam int CFS_NUM_MASKS = 4;
  localparam int CFS_NUM_FIFOS = 32;
  // Implemented bits of an acceptance mask: 31:21, 19, 17:0
  localparam logic [31:0] CFS_MASK_IMPL = 32'hFFEB_FFFF;
  localparam int CFS_MASK_IDE_BIT = 19;
  localparam logic [31:0] CFS_WORD_RESET = 32'h0000_0000;
  // Control register fields
  localparam int CFS_CTRL_CAP_BIT = 20;
  localparam int CFS_CTRL_MODE_LSB = 21;
  localparam logic [2:0] CFS_MODE_CONFIG = 3'h4;
  localparam logic [2:0] CFS_MODE_RESET = 3'h4;
  // Interrupt status bit positions
  localparam int CFS_IRQ_TMR_BIT = 0;
  localparam int CFS_IRQ_OVF_BIT = 1;
  localparam int CFS_IRQ_W = 2;
  localparam logic [15:0] CFS_CNT_RESET = 16'h0000;
  localparam logic [15:0] CFS_CNT_MAX = 16'hFFFF;
endpackage

// [design/cfs_mask_match.sv]
// Acceptance comparator for one mask against one filter and one message.
// Assumes identifiers arrive as 11-bit standard plus 18-bit extended parts.
`timescale 1ns/100ps
module cfs_mask_match import cfs_pkg::*; (
  input wire logic [31:0] maskWord,
  input wire logic [10:0] fltStd,
  input wire logic [17:0] fltExt,
  input wire logic fltIsExt,
  input wire logic [10:0] msgStd,
  input wire logic [17:0] msgExt,
  input wire logic msgIsExt,
  output logic hit
);
  wire logic [10:0] stdMask = maskWord[31:21];
  wire logic [17:0] extMask = maskWord[17:0];
  wire logic identTypeMatch = maskWord[CFS_MASK_IDE_BIT];
  wire logic stdEq = ((fltStd ^ msgStd) & stdMask) == 11'h000;
  wire logic extEq = ((fltExt ^ msgExt) & extMask) == 18'h00000;
  wire logic idEq = msgIsExt ? (stdEq && extEq) : stdEq;
  wire logic typeOk = !identTypeMatch || (fltIsExt == msgIsExt);
  assign hit = idEq && typeOk;
endmodule // cfs_mask_match

// [design/cfs_status_timer.sv]
// Top: FIFO pending/overflow status, timestamp timer, acceptance masks,
// control and interrupt registers behind an APB slave.
// Assumes one clock, synchronous active-high reset, FIFO event inputs
// synchronous to core_clk.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - Pending word: bit per FIFO, one while any enabled interrupt pending.
// - Overflow word: bit per FIFO, set once that FIFO overflowed.
// - Upper timer half counts once per prescale period while capture enabled.
// - Prescale zero counts every clock; value N counts every N clocks.
// - Capture disabled freezes the whole timer register.
// - Any timer write restarts the prescale count, keeps written prescale.
// - Four masks: standard id 31:21, type match 19, extended 17:0.
// - Unimplemented mask bits ignore writes and read zero.
// - Mask one compares the id bit, zero makes it don't-care.
// - Type match one requires format agreement; zero accepts either.
// - Mask writes only take effect in configuration mode 100.
// - Timestamp overflow sets the timer overflow flag.
module cfs_status_timer import cfs_pkg::*; #(
  parameter int NUM_FIFOS = CFS_NUM_FIFOS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_FIFOS-1:0] fifoIrqCond,
  input wire logic [NUM_FIFOS-1:0] fifoOverflowEvt,
  input wire logic [1:0] fltMaskSel,
  input wire logic [10:0] fltStd,
  input wire logic [17:0] fltExt,
  input wire logic fltIsExt,
  input wire logic [10:0] msgStd,
  input wire logic [17:0] msgExt,
  input wire logic msgIsExt,
  output logic maskHit,
  output logic [2:0] operatingModeField,
  output logic timerOverflowFlag,
  output logic irq
);
  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] off);
    isAddr = (a == off);
  endfunction

  logic [NUM_FIFOS-1:0] fifoPend_q;
  logic [NUM_FIFOS-1:0] rx_fifo_overflowed_q;
  logic [15:0] tsCount_q;
  logic [15:0] tsPrescale_q;
  logic [15:0] preCnt_q;
  logic capEn_q;
  logic [2:0] opMode_q;
  logic [CFS_IRQ_W-1:0] irqStat_q;
  logic [CFS_IRQ_W-1:0] irqMask_q;
  logic [31:0] mask_q [CFS_NUM_MASKS];
  logic [31:0] prdata_q;

  wire logic access = psel && penable && clkEn;
  wire logic wrAcc = access && pwrite;
  wire logic rdAcc = access && !pwrite;
  wire logic selMask = (paddr[7:4] == CFS_OFF_MASK0[7:4]) && (paddr[3:2] <= 2'h3)
    && (paddr[1:0] == 2'h0);
  wire logic [1:0] maskIdx = paddr[3:2];
  wire logic selKnown = isAddr(paddr, CFS_OFF_FIFO_PEND) || isAddr(paddr, CFS_OFF_RX_OVF)
    || isAddr(paddr, CFS_OFF_TIMER) || isAddr(paddr, CFS_OFF_CTRL)
    || isAddr(paddr, CFS_OFF_IRQ_STAT) || isAddr(paddr, CFS_OFF_IRQ_MASK) || selMask;
  wire logic wrTimer = wrAcc && isAddr(paddr, CFS_OFF_TIMER);
  wire logic wrCtrl = wrAcc && isAddr(paddr, CFS_OFF_CTRL);
  wire logic wrIrqStat = wrAcc && isAddr(paddr, CFS_OFF_IRQ_STAT);
  wire logic wrIrqMask = wrAcc && isAddr(paddr, CFS_OFF_IRQ_MASK);
  wire logic inConfig = (opMode_q == CFS_MODE_CONFIG);
  wire logic wrMask = wrAcc && selMask && inConfig;

  wire logic preDone = (tsPrescale_q == 16'h0000) || (preCnt_q >= tsPrescale_q - 16'h0001);
  wire logic tsTick = capEn_q && preDone && !wrTimer;
  wire logic tsWrap = tsTick && (tsCount_q == CFS_CNT_MAX);
  wire logic [CFS_IRQ_W-1:0] irqEvt = {|fifoOverflowEvt, tsWrap};

  // Next values as named wires; register blocks below only load them, except the masks, which load pwdata & CFS_MASK_IMPL
  wire logic [NUM_FIFOS-1:0] fifoPend_d = fifoIrqCond;
  wire logic [NUM_FIFOS-1:0] rx_fifo_overflowed_d = rx_fifo_overflowed_q | fifoOverflowEvt;
  wire logic [15:0] preCntInc = preCnt_q + 16'h0001;
  wire logic [15:0] preCntRun = preDone ? CFS_CNT_RESET : preCntInc;
  // Prescale count holds while capture is off, so a restart resumes the period
  wire logic [15:0] preCnt_d = wrTimer ? CFS_CNT_RESET : (capEn_q ? preCntRun : preCnt_q);
  wire logic [15:0] tsCountInc = tsCount_q + 16'h0001;
  wire logic [15:0] tsCount_d = wrTimer ? pwdata[31:16] : (tsTick ? tsCountInc : tsCount_q);
  wire logic [15:0] tsPrescale_d = wrTimer ? pwdata[15:0] : tsPrescale_q;
  wire logic capEn_d = wrCtrl ? pwdata[CFS_CTRL_CAP_BIT] : capEn_q;
  wire logic [2:0] opMode_d = wrCtrl ? pwdata[CFS_CTRL_MODE_LSB +: 3] : opMode_q;
  wire logic [CFS_IRQ_W-1:0] irqMask_d = wrIrqMask ? pwdata[CFS_IRQ_W-1:0] : irqMask_q;
  wire logic [CFS_IRQ_W-1:0] irqClr = wrIrqStat ? pwdata[CFS_IRQ_W-1:0] : '0;
  wire logic [CFS_IRQ_W-1:0] irqStat_d = (irqStat_q & ~irqClr) | irqEvt;

  genvar fi;
  generate
    for (fi = 0; fi < NUM_FIFOS; fi++) begin : gFifo
      always_ff @(posedge core_clk) begin
        if (srst) begin
          fifoPend_q[fi] <= 1'b0;
        end else if (clkEn) begin
          fifoPend_q[fi] <= fifoPend_d[fi];
        end
      end

      always_ff @(posedge core_clk) begin
        if (srst) begin
          rx_fifo_overflowed_q[fi] <= 1'b0;
        end else if (clkEn) begin
          rx_fifo_overflowed_q[fi] <= rx_fifo_overflowed_d[fi];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (srst) begin
      preCnt_q <= CFS_CNT_RESET;
    end else if (clkEn) begin
      preCnt_q <= preCnt_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tsCount_q <= CFS_CNT_RESET;
    end else if (clkEn) begin
      tsCount_q <= tsCount_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tsPrescale_q <= CFS_CNT_RESET;
    end else if (clkEn) begin
      tsPrescale_q <= tsPrescale_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      capEn_q <= 1'b0;
    end else if (clkEn) begin
      capEn_q <= capEn_d;
    end
  end

  // Comes out of reset in configuration mode so masks can be loaded first
  always_ff @(posedge core_clk) begin
    if (srst) begin
      opMode_q <= CFS_MODE_RESET;
    end else if (clkEn) begin
      opMode_q <= opMode_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irqMask_q <= '0;
    end else if (clkEn) begin
      irqMask_q <= irqMask_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irqStat_q <= '0;
    end else if (clkEn) begin
      irqStat_q <= irqStat_d;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CFS_NUM_MASKS; gi++) begin : gMask
      always_ff @(posedge core_clk) begin
        if (srst) begin
          mask_q[gi] <= CFS_WORD_RESET;
        end else if (clkEn && wrMask && (maskIdx == 2'(gi))) begin
          mask_q[gi] <= pwdata & CFS_MASK_IMPL;
        end
      end
    end
  endgenerate

  wire logic [31:0] ctrlWord = {8'h00, opMode_q, capEn_q, 20'h00000};
  wire logic [31:0] fifoPendWord = 32'(fifoPend_q);
  wire logic [31:0] rxOvfWord = 32'(rx_fifo_overflowed_q);
  wire logic [31:0] rdMux =
    isAddr(paddr, CFS_OFF_FIFO_PEND) ? fifoPendWord :
    isAddr(paddr, CFS_OFF_RX_OVF) ? rxOvfWord :
    isAddr(paddr, CFS_OFF_TIMER) ? {tsCount_q, tsPrescale_q} :
    isAddr(paddr, CFS_OFF_CTRL) ? ctrlWord :
    isAddr(paddr, CFS_OFF_IRQ_STAT) ? 32'(irqStat_q) :
    isAddr(paddr, CFS_OFF_IRQ_MASK) ? 32'(irqMask_q) :
    selMask ? mask_q[maskIdx] : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata_q <= 32'h0000_0000;
    end else if (clkEn && psel && !penable && !pwrite) begin
      prdata_q <= rdMux;
    end
  end

  // Read data captured in setup so access completes with zero wait states
  assign prdata = prdata_q;
  assign pready = clkEn;
  assign pslverr = psel && penable && !selKnown;

  cfs_mask_match uMatch (
    .maskWord(mask_q[fltMaskSel]),
    .fltStd(fltStd),
    .fltExt(fltExt),
    .fltIsExt(fltIsExt),
    .msgStd(msgStd),
    .msgExt(msgExt),
    .msgIsExt(msgIsExt),
    .hit(maskHit)
  );

  assign operatingModeField = opMode_q;
  assign timerOverflowFlag = irqStat_q[CFS_IRQ_TMR_BIT];
  assign irq = |(irqStat_q & irqMask_q);
  wire logic unusedRd = rdAcc;
endmodule // cfs_status_timer

// [testbench/cfs_fifo_model.sv]
// Far-side stand-in: FIFO engine raising interrupt conditions and overflow pulses.
// Assumes the bench holds each request; outputs change only on core_clk.
`timescale 1ns/100ps
module cfs_fifo_model (
  input wire logic core_clk,
  input wire logic [31:0] condReq,
  input wire logic [4:0] ovfIdx,
  input wire logic ovfReq,
  output logic [31:0] fifoIrqCond,
  output logic [31:0] fifoOverflowEvt
);
  always_ff @(posedge core_clk) begin
    fifoIrqCond <= condReq;
    fifoOverflowEvt <= ovfReq ? 32'h1 << ovfIdx : 32'h0;
  end
endmodule // cfs_fifo_model

// [testbench/cfs_status_timer_asserts.sv]
// Checker: reset, APB decode, mode, flag and comparator relations at top ports.
// Assumes one clock domain, core_clk, with srst.
`timescale 1ns/100ps
module cfs_status_timer_asserts (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [10:0] fltStd,
  input wire logic [17:0] fltExt,
  input wire logic fltIsExt,
  input wire logic [10:0] msgStd,
  input wire logic [17:0] msgExt,
  input wire logic msgIsExt,
  input wire logic maskHit,
  input wire logic [2:0] operatingModeField,
  input wire logic timerOverflowFlag,
  input wire logic irq
);
  wire acc = psel && penable;
  wire bad = paddr > 8'h2C || paddr == 8'h18 || paddr == 8'h1C || paddr[1:0] != 2'h0;
  wire wrCtl = acc && pwrite && paddr == 8'h0C;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  chk_reset_state: assert property (disable iff (1'b0) srst && clkEn |=>
    operatingModeField == 3'h4 && !timerOverflowFlag && !irq) else $error("bad reset state");
  chk_mode_write: assert property (wrCtl && pready |=>
    operatingModeField == $past(pwdata[23:21])) else $error("mode not written");
  chk_mode_hold: assert property (!wrCtl |=> $stable(operatingModeField))
    else $error("mode changed alone");
  chk_slverr_map: assert property (acc |-> pslverr == bad) else $error("slverr decode");
  chk_hole_zero: assert property (acc && !pwrite && pready && bad |-> prdata == 0)
    else $error("hole read nonzero");
  chk_equal_hit: assert property (fltStd == msgStd && fltExt == msgExt
    && fltIsExt == msgIsExt |-> maskHit) else $error("equal ids missed");
  chk_flag_sticky: assert property (timerOverflowFlag &&
    !(acc && pwrite && paddr == 8'h10 && pwdata[0]) |=> timerOverflowFlag)
    else $error("flag dropped");
  chk_stall_frozen: assert property (!clkEn |=>
    $stable(operatingModeField) && $stable(timerOverflowFlag)) else $error("moved in stall");
  cov_flag: cover property ($rose(timerOverflowFlag));
  cov_hit: cover property (maskHit && msgIsExt != fltIsExt);
  cov_err: cover property (acc && pslverr);
endmodule // cfs_status_timer_asserts
bind cfs_status_timer cfs_status_timer_asserts cfs_status_timer_asserts_i (.*);

// [testbench/cfs_status_timer_tb_top.sv]
// Bench: register, timer, FIFO status and comparator scenarios over APB.
// Assumes the checker binds itself; clkEn low only in one stall window.
`timescale 1ns/100ps
module cfs_status_timer_tb_top import cfs_pkg::*;;
  logic core_clk = 0, srst = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
  logic fltIsExt = 0, msgIsExt = 0, ovfReq = 0, pready, pslverr, maskHit, timerOverflowFlag, irq;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, condReq = 0, r, s, prdata, fifoIrqCond, fifoOverflowEvt;
  logic [1:0] fltMaskSel = 0;
  logic [10:0] fltStd = 0, msgStd = 0;
  logic [17:0] fltExt = 0, msgExt = 0;
  logic [4:0] ovfIdx = 0;
  logic [2:0] operatingModeField;
  int n_mismatch = 0, n_tests = 0;
  cfs_status_timer cfs_status_timer_i (.*);
  cfs_fifo_model cfs_fifo_model_i (.core_clk(core_clk), .condReq(condReq), .ovfIdx(ovfIdx),
    .ovfReq(ovfReq), .fifoIrqCond(fifoIrqCond), .fifoOverflowEvt(fifoOverflowEvt));
  initial forever #25 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task automatic hit(input logic [10:0] sd, input logic x, input logic e);
    msgStd <= sd;
    msgIsExt <= x;
    repeat (2) @(posedge core_clk);
    chk({31'h0, maskHit}, {31'h0, e});
  endtask
  task t_reset;
    for (int i = 0; i < 12; i++) rd(8'(4 * i), i == 3 ? 32'h0080_0000 : 32'h0);
    $display("reset test done");
  endtask
  task t_mask;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CFS_OFF_MASK0 + 8'(4 * i), 32'hFFFF_FFFF);
      rd(CFS_OFF_MASK0 + 8'(4 * i), CFS_MASK_IMPL);
    end
    apb(1'b1, CFS_OFF_MASK0 + 8'h04, 32'hFFF7_FFFF);
    hit(11'h001, 1'b0, 1'b0);
    hit(11'h000, 1'b1, 1'b0);
    fltMaskSel <= 2'h1;
    hit(11'h000, 1'b1, 1'b1);
    apb(1'b1, CFS_OFF_CTRL, 32'h0);
    apb(1'b1, CFS_OFF_MASK0, 32'h0);
    rd(CFS_OFF_MASK0, CFS_MASK_IMPL);
    apb(1'b1, CFS_OFF_CTRL, 32'h0080_0000);
    $display("mask test done");
  endtask
  task t_timer;
    apb(1'b1, CFS_OFF_TIMER, 32'h0000_FFFF);
    apb(1'b1, CFS_OFF_CTRL, 32'h0090_0000);
    apb(1'b1, CFS_OFF_CTRL, 32'h0080_0000);
    rd(CFS_OFF_TIMER, 32'h0000_FFFF);
    apb(1'b1, CFS_OFF_TIMER, 32'hFFFF_0000);
    rd(CFS_OFF_TIMER, 32'hFFFF_0000);
    apb(1'b1, CFS_OFF_CTRL, 32'h0090_0000);
    apb(1'b1, CFS_OFF_CTRL, 32'h0080_0000);
    apb(1'b0, CFS_OFF_TIMER, 32'h0);
    s = r;
    chk(s, 32'h0002_0000);
    rd(CFS_OFF_TIMER, s);
    rd(CFS_OFF_IRQ_STAT, 32'h1);
    apb(1'b1, CFS_OFF_IRQ_STAT, 32'h1);
    rd(CFS_OFF_IRQ_STAT, 32'h0);
    // Three enabled cycles with a period of two give exactly one tick
    apb(1'b1, CFS_OFF_TIMER, 32'h0000_0002);
    apb(1'b1, CFS_OFF_CTRL, 32'h0090_0000);
    apb(1'b1, CFS_OFF_CTRL, 32'h0080_0000);
    rd(CFS_OFF_TIMER, 32'h0001_0002);
    $display("timer test done");
  endtask
  task t_fifo;
    condReq <= 32'h8000_0001;
    // Condition passes the model and the pending register before it reads
    repeat (3) @(posedge core_clk);
    rd(CFS_OFF_FIFO_PEND, 32'h8000_0001);
    condReq <= 32'h0;
    repeat (3) @(posedge core_clk);
    rd(CFS_OFF_FIFO_PEND, 32'h0);
    ovfIdx <= 5'd31;
    ovfReq <= 1'b1;
    @(posedge core_clk);
    ovfReq <= 1'b0;
    // Let the model's pulse reach the design before the stall starts
    @(posedge core_clk);
    clkEn <= 1'b0;
    repeat (3) @(posedge core_clk);
    clkEn <= 1'b1;
    rd(CFS_OFF_RX_OVF, 32'h8000_0000);
    apb(1'b1, CFS_OFF_IRQ_MASK, 32'h2);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, CFS_OFF_IRQ_STAT, 32'h2);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    rd(CFS_OFF_RX_OVF, 32'h8000_0000);
    rd(8'h30, 32'h0);
    $display("fifo test done");
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    t_reset;
    t_mask;
    t_timer;
    t_fifo;
    print_verdict;
  end
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict;
  end
endmodule // cfs_status_timer_tb_top
